// File: hw/radio_irq_ctrl.sv
// interrupt status and enable block with an axi4-lite register port
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Functional notes
// (R01) sync status bit 7 sets on sync word, drops when packet reception ends
// (R02) valid preamble bit 6 sets on preamble, drops on sync or sync wait timeout
// (R03) invalid preamble bit 5 clears itself while its enable is 0; host treats it as interrupt only
// (R04) signal strength bit 4 stays high while level is above threshold; code sets it only on the rise, so a read clears it while enabled
// (R05) host uses wake timer bit 3 as an event, not lasting status
// (R06) low battery bit 2 latches even when disabled, interrupts once enabled
// (R07) ready bit 1 rises after oscillator settling, holds until idle; code also clears it on a read while enabled
// (R08) enable register one: eight read/write enables of the first group
// (R09) enable register two: eight enables of the second group, 1 enables
// (R10) sync and preamble enables act only while preamble mask bit is 1
// (R11) enabled status bit going high drives the interrupt pin low
// (R12) status read releases the pin and clears every enabled bit
// (R13) disabled bits are plain status, unchanged by a read
// (R14) all enabled pending events of both groups share one low interrupt
// ----------------------------------------------------------------
module radio_irq_ctrl #(
   parameter int SETTLE_CYC = radio_irq_pkg::OSC_SETTLE_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [radio_irq_pkg::AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [radio_irq_pkg::AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [7:0] GRP1_EVT,
   input radio_irq_pkg::grp2_evt_t GRP2_EVT,
   output logic HOST_IRQ_N
);
   import radio_irq_pkg::*;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic reg_id_t decode(input logic [AXI_AW-1:0] addr);
      reg_id_t id;
      id = REG_NONE;
      if (addr[1:0] != 2'h0) begin
         id = REG_NONE;
      end else if (addr[AXI_AW-1:2] == IDX_STATUS_ONE) begin
         id = REG_ST1;
      end else if (addr[AXI_AW-1:2] == IDX_STATUS_TWO) begin
         id = REG_ST2;
      end else if (addr[AXI_AW-1:2] == IDX_ENABLE_ONE) begin
         id = REG_EN1;
      end else if (addr[AXI_AW-1:2] == IDX_ENABLE_TWO) begin
         id = REG_EN2;
      end else if (addr[AXI_AW-1:2] == IDX_CONTROL) begin
         id = REG_CTRL;
      end
      return id;
   endfunction

   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic aw_hold_r;
   logic w_hold_r;
   logic aw_take;
   logic w_take;
   logic do_wr;
   logic aw_hold_nxt;
   logic w_hold_nxt;
   wr_req_t wr_q_r;
   reg_id_t wsel;

   logic arready_r;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic ar_take;
   reg_id_t rsel;
   logic rd1;
   logic rd2;

   logic [7:0] en1_r;
   logic [7:0] en2_r;
   logic premask_r;
   logic [7:0] en2_eff;
   logic [7:0] st1_r;
   logic [7:0] st2;
   logic any_pend;
   logic irq_n_r;

   assign S_AXI_AWREADY = awready_r;
   assign S_AXI_WREADY = wready_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_ARREADY = arready_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;
   assign HOST_IRQ_N = irq_n_r;

   // ----------------------------------------------------------------
   // write channel: address and data in either order
   // ----------------------------------------------------------------
   assign aw_take = awready_r && S_AXI_AWVALID;
   assign w_take = wready_r && S_AXI_WVALID;
   assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
   assign aw_hold_nxt = (aw_hold_r || aw_take) && !do_wr;
   assign w_hold_nxt = (w_hold_r || w_take) && !do_wr;
   assign wsel = decode(wr_q_r.addr);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awready_r <= !aw_hold_nxt;
         wready_r <= !w_hold_nxt;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wr_q_r <= '0;
      end else begin
         if (aw_take) begin
            wr_q_r.addr <= S_AXI_AWADDR;
         end
         if (w_take) begin
            wr_q_r.data <= S_AXI_WDATA;
            wr_q_r.strb <= S_AXI_WSTRB;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // writable registers; status registers ignore writes
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         en1_r <= EN1_RESET;
      end else if (do_wr && wsel == REG_EN1 && wr_q_r.strb[0]) begin
         en1_r <= wr_q_r.data[7:0]; // R08
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         en2_r <= EN2_RESET;
      end else if (do_wr && wsel == REG_EN2 && wr_q_r.strb[0]) begin
         en2_r <= wr_q_r.data[7:0]; // R09
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         premask_r <= CTRL_RESET;
      end else if (do_wr && wsel == REG_CTRL && wr_q_r.strb[0]) begin
         premask_r <= wr_q_r.data[CTRL_PREMASK_BIT];
      end
   end

   // sync and preamble enables are gated by the mask bit
   assign en2_eff = en2_r & (premask_r ? 8'hFF : ~PREAMBLE_GROUP); // R10

   // ----------------------------------------------------------------
   // read channel: one read at a time, data captured at the take
   // ----------------------------------------------------------------
   assign ar_take = arready_r && S_AXI_ARVALID;
   assign rvalid_nxt = ar_take || (rvalid_r && !S_AXI_RREADY);
   assign rsel = decode(S_AXI_ARADDR);
   assign rd1 = ar_take && rsel == REG_ST1;
   assign rd2 = ar_take && rsel == REG_ST2;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
      end else begin
         arready_r <= !rvalid_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (ar_take) begin
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0000_0000;
         if (rsel == REG_ST1) begin
            rdata_r[7:0] <= st1_r;
         end else if (rsel == REG_ST2) begin
            rdata_r[7:0] <= st2; // R12
         end else if (rsel == REG_EN1) begin
            rdata_r[7:0] <= en1_r;
         end else if (rsel == REG_EN2) begin
            rdata_r[7:0] <= en2_r;
         end else if (rsel == REG_CTRL) begin
            rdata_r[CTRL_PREMASK_BIT] <= premask_r;
         end else begin
            rresp_r <= RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------------------------------
   // first status group: sticky, enabled bits clear on read
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st1_r <= ST1_RESET;
      end else begin
         // a new event in the read cycle survives the clear
         st1_r <= GRP1_EVT | (st1_r & ~(rd1 ? en1_r : 8'h00)); // R14
      end
   end

   // ----------------------------------------------------------------
   // second status group
   // ----------------------------------------------------------------
   irq_status_two #(
      .SETTLE_CYC(SETTLE_CYC)
   ) u_status_two (
      .clk(CLK),
      .rst(RST),
      .evt(GRP2_EVT),
      .en_eff(en2_eff),
      .rd_clr(rd2),
      .status(st2)
   );

   // ----------------------------------------------------------------
   // shared interrupt pin
   // ----------------------------------------------------------------
   assign any_pend = ((st1_r & en1_r) != 8'h00) || ((st2 & en2_eff) != 8'h00); // R14

   // registered so the pin never glitches; costs one cycle of latency
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_n_r <= 1'b1;
      end else begin
         irq_n_r <= !any_pend; // R11
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_irq_low;
      @(posedge CLK) disable iff (RST) any_pend |=> !HOST_IRQ_N;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("pending event did not pull pin low"); // R11

   property p_irq_rise;
      @(posedge CLK) disable iff (RST)
         ($rose(st2[BIT_LBD]) && en2_r[BIT_LBD]) |=> !HOST_IRQ_N;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("enabled status rise missed pin"); // R06

   property p_irq_mask;
      @(posedge CLK) disable iff (RST)
         (!premask_r && ((st1_r & en1_r) == 8'h00) && ((st2 & en2_r & ~PREAMBLE_GROUP) == 8'h00))
         |=> HOST_IRQ_N;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked preamble group raised pin"); // R10

   property p_irq_release;
      @(posedge CLK) disable iff (RST)
         (rd2 && ((st1_r & en1_r) == 8'h00) && (GRP2_EVT == '0) && (GRP1_EVT == 8'h00)
          && (en2_eff[BIT_RSSI] == 1'b0) && (en2_eff[BIT_RDY] == 1'b0))
         |=> ##1 HOST_IRQ_N;
   endproperty
   a_irq_release: assert property (p_irq_release) else $error("status read did not release pin"); // R12

   property p_rd_data;
      @(posedge CLK) disable iff (RST) rd2 |=> (S_AXI_RDATA == {24'h00_0000, $past(st2)}) && S_AXI_RVALID;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("status read returned wrong value"); // R12

   property p_grp1_keep;
      @(posedge CLK) disable iff (RST)
         rd1 |=> ((st1_r & ~$past(en1_r)) == (($past(st1_r) | $past(GRP1_EVT)) & ~$past(en1_r)));
   endproperty
   a_grp1_keep: assert property (p_grp1_keep) else $error("disabled group one bit changed"); // R13

   property p_en1_write;
      @(posedge CLK) disable iff (RST)
         (do_wr && wsel == REG_EN1 && wr_q_r.strb[0]) |=> (en1_r == $past(wr_q_r.data[7:0]));
   endproperty
   a_en1_write: assert property (p_en1_write) else $error("enable one write lost"); // R08

   property p_en2_write;
      @(posedge CLK) disable iff (RST)
         (do_wr && wsel == REG_EN2 && wr_q_r.strb[0]) |=> (en2_r == $past(wr_q_r.data[7:0]));
   endproperty
   a_en2_write: assert property (p_en2_write) else $error("enable two write lost"); // R09

   property p_bresp;
      @(posedge CLK) disable iff (RST) do_wr |=> S_AXI_BVALID;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response missing");

   property p_bhold;
      @(posedge CLK) disable iff (RST) (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped early");

   property p_rhold;
      @(posedge CLK) disable iff (RST) (S_AXI_RVALID && !S_AXI_RREADY) |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped early");

endmodule

// File: hw/radio_irq_pkg.sv
// constants and types for the radio interrupt status and enable block
package radio_irq_pkg;

   // ----------------------------------------------------------------
   // bus and clock
   // ----------------------------------------------------------------
   localparam int AXI_AW = 8;
   localparam int CLK_PERIOD_NS = 5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // oscillator settling, rounded up to whole cycles
   // ----------------------------------------------------------------
   localparam int OSC_SETTLE_NS = 1000;
   localparam int OSC_SETTLE_RAW = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OSC_SETTLE_CYC = (OSC_SETTLE_RAW < 1) ? 1 : OSC_SETTLE_RAW;

   // ----------------------------------------------------------------
   // register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_STATUS_ONE = 6'h03;
   localparam logic [5:0] IDX_STATUS_TWO = 6'h04;
   localparam logic [5:0] IDX_ENABLE_ONE = 6'h05;
   localparam logic [5:0] IDX_ENABLE_TWO = 6'h06;
   localparam logic [5:0] IDX_CONTROL = 6'h08;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] ST1_RESET = 8'h00;
   localparam logic [7:0] ST2_RESET = 8'h01;
   localparam logic [7:0] EN1_RESET = 8'h00;
   localparam logic [7:0] EN2_RESET = 8'h00;
   localparam logic CTRL_RESET = 1'b0;
   localparam int CTRL_PREMASK_BIT = 0;
   localparam logic [7:0] PREAMBLE_GROUP = 8'hE0;
   localparam int BIT_SYNC = 7;
   localparam int BIT_PRE_OK = 6;
   localparam int BIT_PRE_BAD = 5;
   localparam int BIT_RSSI = 4;
   localparam int BIT_WUT = 3;
   localparam int BIT_LBD = 2;
   localparam int BIT_RDY = 1;

   typedef enum logic [2:0] {REG_NONE, REG_ST1, REG_ST2, REG_EN1, REG_EN2, REG_CTRL} reg_id_t;

   typedef struct packed {
      logic sync_found;
      logic pkt_done;
      logic preamble_found;
      logic sync_timeout;
      logic preamble_invalid;
      logic rssi_above;
      logic wut_expired;
      logic low_batt;
      logic osc_req;
   } grp2_evt_t;

   typedef struct packed {
      logic [AXI_AW-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } wr_req_t;

endpackage

// File: hw/irq_status_two.sv
// set and clear logic of the second status group
`timescale 1ns/1ps
module irq_status_two #(
   parameter int SETTLE_CYC = radio_irq_pkg::OSC_SETTLE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input radio_irq_pkg::grp2_evt_t evt,
   input wire logic [7:0] en_eff,
   input wire logic rd_clr,
   output logic [7:0] status
);
   import radio_irq_pkg::*;

   localparam int CW = $clog2(SETTLE_CYC + 1);

   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic [CW-1:0] settle_cnt_r;
   logic ready_r;
   logic rssi_d_r;
   logic settle_done;
   logic [7:0] quiet_mask;

   assign status = status_r;
   assign settle_done = evt.osc_req && !ready_r && (settle_cnt_r == CW'(SETTLE_CYC - 1));
   // bits with no event, no clear condition and no enable: a read must leave them alone
   assign quiet_mask = ~(set_vec | clr_vec | en_eff);

   // ----------------------------------------------------------------
   // oscillator settling
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         settle_cnt_r <= '0;
         ready_r <= 1'b0;
      end else if (!evt.osc_req) begin
         settle_cnt_r <= '0; // R07
         ready_r <= 1'b0;
      end else if (settle_done) begin
         ready_r <= 1'b1; // R07
      end else if (!ready_r) begin
         settle_cnt_r <= settle_cnt_r + CW'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rssi_d_r <= 1'b0;
      end else begin
         rssi_d_r <= evt.rssi_above;
      end
   end

   // ----------------------------------------------------------------
   // status bits: set wins over every clear
   // ----------------------------------------------------------------
   always_comb begin
      set_vec = 8'h00;
      clr_vec = 8'h00;
      set_vec[BIT_SYNC] = evt.sync_found; // R01
      clr_vec[BIT_SYNC] = evt.pkt_done; // R01
      set_vec[BIT_PRE_OK] = evt.preamble_found; // R02
      clr_vec[BIT_PRE_OK] = evt.sync_found | evt.sync_timeout; // R02
      set_vec[BIT_PRE_BAD] = evt.preamble_invalid;
      clr_vec[BIT_PRE_BAD] = !en_eff[BIT_PRE_BAD]; // R03
      set_vec[BIT_RSSI] = evt.rssi_above & !rssi_d_r; // R04
      clr_vec[BIT_RSSI] = !evt.rssi_above; // R04
      set_vec[BIT_WUT] = evt.wut_expired;
      clr_vec[BIT_WUT] = !en_eff[BIT_WUT];
      set_vec[BIT_LBD] = evt.low_batt; // R06
      set_vec[BIT_RDY] = settle_done; // R07
      clr_vec[BIT_RDY] = !evt.osc_req; // R07
      // only enabled bits clear on read, plain status bits stay
      status_nxt = set_vec | (status_r & ~clr_vec & ~(rd_clr ? en_eff : 8'h00)); // R12 R13
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_r <= ST2_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_sync_drop;
      @(posedge clk) disable iff (rst) (evt.pkt_done && !evt.sync_found) |=> !status_r[BIT_SYNC];
   endproperty
   a_sync_drop: assert property (p_sync_drop) else $error("sync status kept after packet end"); // R01

   property p_pre_drop;
      @(posedge clk) disable iff (rst)
         ((evt.sync_found || evt.sync_timeout) && !evt.preamble_found) |=> !status_r[BIT_PRE_OK];
   endproperty
   a_pre_drop: assert property (p_pre_drop) else $error("preamble status kept after sync"); // R02

   property p_inval_self;
      @(posedge clk) disable iff (rst)
         (!evt.preamble_invalid && !en_eff[BIT_PRE_BAD]) |=> !status_r[BIT_PRE_BAD];
   endproperty
   a_inval_self: assert property (p_inval_self) else $error("invalid preamble did not self clear"); // R03

   property p_rssi;
      @(posedge clk) disable iff (rst) $rose(evt.rssi_above) |=> status_r[BIT_RSSI] ##1 (!evt.rssi_above || status_r[BIT_RSSI] || $past(rd_clr));
   endproperty
   a_rssi: assert property (p_rssi) else $error("rssi status not held"); // R04

   property p_lbd;
      @(posedge clk) disable iff (rst) evt.low_batt |=> status_r[BIT_LBD];
   endproperty
   a_lbd: assert property (p_lbd) else $error("low battery event lost"); // R06

   property p_rdy_idle;
      @(posedge clk) disable iff (rst) !evt.osc_req |=> !status_r[BIT_RDY] && !ready_r;
   endproperty
   a_rdy_idle: assert property (p_rdy_idle) else $error("ready status held in idle"); // R07

   property p_rd_clear;
      @(posedge clk) disable iff (rst)
         (rd_clr && ((set_vec & en_eff) == 8'h00)) |=> ((status_r & $past(en_eff)) == 8'h00);
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("enabled bit not cleared by read"); // R12

   property p_rd_keep;
      @(posedge clk) disable iff (rst)
         rd_clr |=> (((status_r ^ $past(status_r)) & $past(quiet_mask)) == 8'h00);
   endproperty
   a_rd_keep: assert property (p_rd_keep) else $error("plain status changed by read"); // R13

endmodule

// File: tb/host_irq_model.sv
// host side model that counts interrupt pin assertions
`timescale 1ns/1ps
module host_irq_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic irq_n,
   output int falls
);
   // ----------------------------------------------------------------
   // pin watcher
   // ----------------------------------------------------------------
   logic last_r;
   // bits 5 and 3 are serviced as events on the pin, never polled as lasting status
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_r <= 1'b1;
         falls <= 0;
      end else begin
         last_r <= irq_n;
         if (last_r && !irq_n) falls <= falls + 1;
      end
   end
endmodule

// File: tb/radio_irq_status_and_enable_test.sv
// self-checking bench for the radio interrupt status and enable block
`timescale 1ns/1ps
module radio_irq_status_and_enable_test;
   import radio_irq_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   // short settle count keeps the ready test fast
   localparam int ST = 4;
   localparam logic [7:0] A_ST1 = {IDX_STATUS_ONE, 2'b00};
   localparam logic [7:0] A_ST2 = {IDX_STATUS_TWO, 2'b00};
   localparam logic [7:0] A_EN1 = {IDX_ENABLE_ONE, 2'b00};
   localparam logic [7:0] A_EN2 = {IDX_ENABLE_TWO, 2'b00};
   localparam logic [7:0] A_CT = {IDX_CONTROL, 2'b00};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [7:0] g1 = 8'h00;
   grp2_evt_t g2 = '0;
   logic awready, wready, bvalid, arready, rvalid, irq_n;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int falls;
   int err_count = 0;
   int n_compared = 0;
   always #2.5 clk = ~clk;
   radio_irq_ctrl #(.SETTLE_CYC(ST)) radio_irq_ctrl_inst (
      .CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .GRP1_EVT(g1), .GRP2_EVT(g2), .HOST_IRQ_N(irq_n));
   host_irq_model host_irq_model_inst (.clk(clk), .rst(rst), .irq_n(irq_n), .falls(falls));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // two edges let the status and pin registers settle first
   task chk_irq(input logic exp);
      repeat (2) @(posedge clk);
      #1;
      n_compared++;
      if (irq_n !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t irq pin %b exp %b", $time, irq_n, exp);
      end
   endtask
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready) begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(ad && dd));
      while (!bvalid) @(posedge clk);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, RESP_OKAY});
   endtask
   task rdc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge clk);
      rready <= 1'b0;
      chk(rdata, {24'h0, d});
      chk({30'h0, rresp}, {30'h0, r});
   endtask
   task pulse(input grp2_evt_t e);
      @(posedge clk);
      g2 <= g2 | e;
      @(posedge clk);
      g2 <= g2 & ~e;
      repeat (2) @(posedge clk);
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      #100000;
      err_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      end_sim;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rdc(A_ST2, 8'h01, RESP_OKAY);
      rdc(A_ST2, 8'h01, RESP_OKAY);
      rdc(A_EN1, 8'h00, RESP_OKAY);
      rdc(A_EN2, 8'h00, RESP_OKAY);
      rdc(8'h1C, 8'h00, RESP_SLVERR);
      chk_irq(1'b1);
      wr(A_EN1, 8'hA5);
      rdc(A_EN1, 8'hA5, RESP_OKAY);
      wr(A_EN2, 8'h5A);
      rdc(A_EN2, 8'h5A, RESP_OKAY);
      wr(A_EN2, 8'h00);
      pulse(9'h002);
      rdc(A_ST2, 8'h05, RESP_OKAY);
      chk_irq(1'b1);
      wr(A_EN2, 8'h04);
      chk_irq(1'b0);
      rdc(A_ST2, 8'h05, RESP_OKAY);
      chk_irq(1'b1);
      rdc(A_ST2, 8'h01, RESP_OKAY);
      wr(A_EN2, 8'h00);
      pulse(9'h040);
      rdc(A_ST2, 8'h41, RESP_OKAY);
      pulse(9'h100);
      rdc(A_ST2, 8'h81, RESP_OKAY);
      pulse(9'h080);
      rdc(A_ST2, 8'h01, RESP_OKAY);
      pulse(9'h040);
      pulse(9'h020);
      rdc(A_ST2, 8'h01, RESP_OKAY);
      wr(A_EN2, 8'h80);
      pulse(9'h100);
      chk_irq(1'b1);
      rdc(A_ST2, 8'h81, RESP_OKAY);
      wr(A_CT, 8'h01);
      chk_irq(1'b0);
      rdc(A_CT, 8'h01, RESP_OKAY);
      rdc(A_ST2, 8'h81, RESP_OKAY);
      rdc(A_ST2, 8'h01, RESP_OKAY);
      wr(A_EN2, 8'h08);
      @(posedge clk);
      g2.rssi_above <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(A_ST2, 8'h11, RESP_OKAY);
      rdc(A_ST2, 8'h11, RESP_OKAY);
      g2.rssi_above <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(A_ST2, 8'h01, RESP_OKAY);
      g2.osc_req <= 1'b1;
      rdc(A_ST2, 8'h01, RESP_OKAY);
      repeat (ST + 2) @(posedge clk);
      rdc(A_ST2, 8'h03, RESP_OKAY);
      g2.osc_req <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(A_ST2, 8'h01, RESP_OKAY);
      pulse(9'h004);
      chk_irq(1'b0);
      rdc(A_ST2, 8'h09, RESP_OKAY);
      chk_irq(1'b1);
      wr(A_EN2, 8'h00);
      pulse(9'h010);
      rdc(A_ST2, 8'h01, RESP_OKAY);
      @(posedge clk);
      g1 <= 8'h01;
      @(posedge clk);
      g1 <= 8'h00;
      chk_irq(1'b0);
      rdc(A_ST1, 8'h01, RESP_OKAY);
      chk_irq(1'b1);
      chk(falls, 32'h0000_0004);
      end_sim;
   end
endmodule
